// ===== core/cfg_engage_pkg.sv
// constants, types and instruction codes for the test-port configuration engage control
package cfg_engage_pkg;

  // ==========================================================
  // instruction register
  localparam int         IR_W              = 10;
  localparam logic [9:0] INSTR_IO_CHAIN    = 10'h00d;
  localparam logic [9:0] INSTR_PULSE_RECFG = 10'h001;
  localparam logic [9:0] INSTR_IDLE_CTRL   = 10'h2d0;
  localparam logic [9:0] INSTR_RESUME_CTRL = 10'h2b0;
  localparam logic [9:0] INSTR_PROGRAM     = 10'h002;
  localparam logic [9:0] INSTR_CHECK       = 10'h004;
  localparam logic [9:0] INSTR_WAKEUP      = 10'h003;
  localparam logic [9:0] INSTR_BYPASS      = 10'h3ff;

  // ==========================================================
  // scheme select encoding
  localparam logic [1:0] SCHEME_SERIAL_PULL = 2'h0;
  localparam logic [1:0] SCHEME_WIDE_PULL   = 2'h1;
  localparam logic [1:0] SCHEME_SERIAL_PUSH = 2'h2;
  localparam logic [1:0] SCHEME_PARALLEL_PUSH = 2'h3;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int MIN_REQ_LOW_NS  = 500;
  localparam int MIN_REQ_LOW_CYC = (MIN_REQ_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RECFG_PULSE_CYC = MIN_REQ_LOW_CYC;
  localparam int CNT_W           = 8;

  // ==========================================================
  // register map
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_INSTR   = 8'h08;
  localparam int CTL_USER_MODE  = 0;
  localparam int CTL_POWERED_UP = 1;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_DECERR = 2'h3;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR,
    TAP_EX2_IR, TAP_UPD_IR
  } tap_state_t;

endpackage

// ===== core/tap_fsm.sv
// boundary-scan state machine with instruction shift and update
`timescale 1ns/100ps
module tap_fsm
  import cfg_engage_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            tck_rise,
  input  wire logic            tms,
  input  wire logic            tdi,
  output logic      [IR_W-1:0] instr,
  output logic                 ir_update,
  output logic                 tap_reset
);

  tap_state_t            state;
  tap_state_t            next_state;
  logic       [IR_W-1:0] shift_ir;

  // ==========================================================
  // next state
  always_comb begin
    next_state = state;
    unique case (state)
      TAP_RESET:  next_state = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   next_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_state = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_state = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  next_state = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_state = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: next_state = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: next_state = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_state = tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: next_state = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  next_state = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_state = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: next_state = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: next_state = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= TAP_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // instruction shift, lsb first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_ir <= '0;
    end else if (tck_rise && state == TAP_CAP_IR) begin
      shift_ir <= INSTR_BYPASS;
    end else if (tck_rise && state == TAP_SH_IR) begin
      shift_ir <= {tdi, shift_ir[IR_W-1:1]};
    end
  end

  // new instruction becomes active leaving update-ir
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr     <= INSTR_BYPASS;
      ir_update <= 1'b0;
    end else begin
      ir_update <= tck_rise && state == TAP_UPD_IR;
      if (tck_rise && state == TAP_UPD_IR) begin
        instr <= shift_ir;
      end else if (tck_rise && next_state == TAP_RESET && state != TAP_RESET) begin
        instr <= INSTR_BYPASS;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tap_reset <= 1'b0;
    end else begin
      tap_reset <= tck_rise && state != TAP_RESET && next_state == TAP_RESET;
    end
  end

endmodule

// ===== core/jtag_config_engage_control.sv
// test-port configuration engage control with axi4-lite status window
`timescale 1ns/100ps
module jtag_config_engage_control
  import cfg_engage_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  input  wire logic [1:0]  scheme_select,
  input  wire logic        reconfig_req_n,
  input  wire logic        program_done,
  output logic             io_chain_reload,
  output logic             user_io_hiz,
  output logic             serial_push_idle,
  output logic             parallel_push_idle,
  output logic             serial_push_resume,
  output logic             parallel_push_resume,
  output logic             reconfig_start,
  output logic             config_status_n_o,
  output logic             config_status_n_oe,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ==========================================================
  // pin synchronisers, three stages, change when 2 and 3 agree
  logic [2:0] tck_s;
  logic [2:0] tms_s;
  logic [2:0] tdi_s;
  logic [2:0] req_s;
  logic       tck_q;
  logic       tms_q;
  logic       tdi_q;
  logic       req_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tck_s <= '0;
      tms_s <= 3'h7;
      tdi_s <= '0;
      req_s <= 3'h7;
    end else begin
      tck_s <= {tck_s[1:0], tck};
      tms_s <= {tms_s[1:0], tms};
      tdi_s <= {tdi_s[1:0], tdi};
      req_s <= {req_s[1:0], reconfig_req_n};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tck_q <= 1'b0;
      tms_q <= 1'b1;
      tdi_q <= 1'b0;
      req_q <= 1'b1;
    end else begin
      if (tck_s[1] == tck_s[2]) tck_q <= tck_s[2];
      if (tms_s[1] == tms_s[2]) tms_q <= tms_s[2];
      if (tdi_s[1] == tdi_s[2]) tdi_q <= tdi_s[2];
      if (req_s[1] == req_s[2]) req_q <= req_s[2];
    end
  end

  // tck edge from the filtered level; one aclk of lag is harmless at 160 ns
  logic tck_prev;
  logic tck_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) tck_prev <= 1'b0;
    else tck_prev <= tck_q;
  end
  assign tck_rise = tck_q && !tck_prev;

  // ==========================================================
  // test-port state machine
  logic [IR_W-1:0] instr;
  logic            ir_update;
  logic            tap_reset;

  tap_fsm u_tap (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tck_rise  (tck_rise),
    .tms       (tms_q),
    .tdi       (tdi_q),
    .instr     (instr),
    .ir_update (ir_update),
    .tap_reset (tap_reset)
  );

  // ==========================================================
  // software-set device state
  logic user_mode;
  logic powered_up;

  function automatic logic is_active(input logic [1:0] s);
    is_active = (s == SCHEME_SERIAL_PUSH) || (s == SCHEME_PARALLEL_PUSH);
  endfunction

  logic active_scheme;
  logic do_io_chain;
  logic do_pulse;
  logic do_idle;
  logic do_resume;

  assign active_scheme = is_active(scheme_select);
  assign do_io_chain   = ir_update && instr == INSTR_IO_CHAIN && powered_up;
  assign do_pulse      = ir_update && instr == INSTR_PULSE_RECFG;
  assign do_idle       = ir_update && instr == INSTR_IDLE_CTRL && active_scheme;
  assign do_resume     = ir_update && instr == INSTR_RESUME_CTRL;

  // ==========================================================
  // io setting chain: reload on update, tri-state while instruction active
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_chain_reload <= 1'b0;
      user_io_hiz     <= 1'b0;
    end else begin
      io_chain_reload <= do_io_chain;
      user_io_hiz     <= powered_up && instr == INSTR_IO_CHAIN;
    end
  end

  // status pin: only ever released, never driven low by the io chain
  assign config_status_n_o  = 1'b0;
  assign config_status_n_oe = 1'b0;

  // ==========================================================
  // controller idle and resume
  logic resumed;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_push_idle   <= 1'b0;
      parallel_push_idle <= 1'b0;
    end else if (do_idle) begin
      serial_push_idle   <= scheme_select == SCHEME_SERIAL_PUSH;
      parallel_push_idle <= scheme_select == SCHEME_PARALLEL_PUSH;
    end else begin
      if (do_resume || program_done || tap_reset) serial_push_idle <= 1'b0;
      if (do_resume || program_done) parallel_push_idle <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_push_resume   <= 1'b0;
      parallel_push_resume <= 1'b0;
    end else begin
      serial_push_resume   <= serial_push_idle && !do_idle
                              && (do_resume || program_done || tap_reset);
      parallel_push_resume <= parallel_push_idle && !do_idle
                              && (do_resume || program_done);
    end
  end

  // once the resume instruction is seen the request pin is ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) resumed <= 1'b0;
    else if (do_resume) resumed <= 1'b1;
  end

  // ==========================================================
  // request pin low-pulse qualification
  logic [CNT_W-1:0] low_cnt;
  logic             req_long;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt  <= '0;
      req_long <= 1'b0;
    end else if (req_q || resumed) begin
      low_cnt  <= '0;
      req_long <= 1'b0;
    end else if (low_cnt != CNT_W'(MIN_REQ_LOW_CYC - 1)) begin
      low_cnt <= low_cnt + CNT_W'(1);
    end else begin
      req_long <= 1'b1;
    end
  end

  logic pin_trigger;
  logic req_long_prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) req_long_prev <= 1'b0;
    else req_long_prev <= req_long;
  end
  // active parallel controller stays idled across a pin request
  assign pin_trigger = req_long && !req_long_prev;

  // ==========================================================
  // reconfiguration trigger
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reconfig_start <= 1'b0;
    end else begin
      reconfig_start <= do_pulse || do_resume || pin_trigger;
    end
  end

  // ==========================================================
  // axi4-lite slave: one write and one read at a time
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  logic wr_ctl;

  assign wr_ctl = aw_held && w_held && aw_addr == OFS_CONTROL && w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      user_mode  <= 1'b0;
      powered_up <= 1'b0;
    end else if (wr_ctl) begin
      user_mode  <= w_data[CTL_USER_MODE];
      powered_up <= w_data[CTL_POWERED_UP];   // io chain inert until set
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (aw_held && w_held) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr == OFS_CONTROL) ? AXI_OKAY : AXI_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= AXI_OKAY;
      unique case (s_axi_araddr)
        OFS_CONTROL: s_axi_rdata <= {30'h0, powered_up, user_mode};
        OFS_STATUS:  s_axi_rdata <= {25'h0, resumed, user_io_hiz, parallel_push_idle,
                                     serial_push_idle, scheme_select, req_q};
        OFS_INSTR:   s_axi_rdata <= {22'h0, instr};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= AXI_DECERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== test/cfg_engage_sva.sv
// assertion checker for the configuration engage control
`timescale 1ns/100ps
module cfg_engage_sva
  import cfg_engage_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [1:0] scheme_select,
  input wire logic       io_chain_reload,
  input wire logic       user_io_hiz,
  input wire logic       serial_push_idle,
  input wire logic       parallel_push_idle,
  input wire logic       serial_push_resume,
  input wire logic       parallel_push_resume,
  input wire logic       reconfig_start,
  input wire logic       config_status_n_oe,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready
);
  // ==========================================================
  // properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_status_never_driven: assert property (!config_status_n_oe)
    else $error("status pin driven");
  a_reload_one_cycle: assert property (io_chain_reload |=> !io_chain_reload)
    else $error("reload longer than one cycle");
  a_hiz_after_reload: assert property (io_chain_reload |-> ##[0:2] user_io_hiz)
    else $error("user pins not released");
  a_serial_idle_scheme: assert property ($rose(serial_push_idle) |->
    scheme_select == SCHEME_SERIAL_PUSH) else $error("serial idle in wrong scheme");
  a_parallel_idle_scheme: assert property ($rose(parallel_push_idle) |->
    scheme_select == SCHEME_PARALLEL_PUSH) else $error("parallel idle in wrong scheme");
  a_serial_resume_clears: assert property (serial_push_resume |-> ##[0:1] !serial_push_idle)
    else $error("serial idle kept after resume");
  // checks parallel idle falls only with a resume pulse (resume instruction or program_done); an idle instruction in the serial push scheme also clears it
  a_parallel_resume_only: assert property ($fell(parallel_push_idle) |->
    parallel_push_resume || $past(parallel_push_resume)) else $error("parallel idle dropped");
  a_start_one_cycle: assert property (reconfig_start |=> !reconfig_start)
    else $error("start longer than one cycle");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response withdrawn");
  a_rresp_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response withdrawn");
endmodule

bind jtag_config_engage_control cfg_engage_sva chk (
  .aclk, .aresetn, .scheme_select, .io_chain_reload, .user_io_hiz, .serial_push_idle,
  .parallel_push_idle, .serial_push_resume, .parallel_push_resume, .reconfig_start,
  .config_status_n_oe, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready
);

// ===== test/tap_host.sv
// test-port host model driving the boundary-scan pins
`timescale 1ns/100ps
module tap_host
  import cfg_engage_pkg::*;
(
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // ==========================================================
  // one 160 ns tck period; tck rests low between frames
  task automatic step(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    #79.7 tck <= 1'b1;
    #80.3 tck <= 1'b0;
  endtask
  // five ones reach reset from anywhere, then park in idle
  task automatic reset_tap();
    repeat (5) step(1'b1, ~tdi);
    step(1'b0, ~tdi);
  endtask
  // select-dr, select-ir, capture, shift lsb first, exit1, update, idle
  task automatic shift_ir(input logic [IR_W-1:0] code);
    step(1'b1, ~tdi);
    step(1'b1, ~tdi);
    step(1'b0, ~tdi);
    step(1'b0, ~tdi);
    for (int i = 0; i < IR_W; i++) step(i == IR_W - 1, code[i]);
    step(1'b1, ~tdi);
    step(1'b0, ~tdi);
  endtask
endmodule

// ===== test/tb_jtag_config_engage_control.sv
// self-checking bench for the configuration engage control
`timescale 1ns/100ps
module tb_jtag_config_engage_control
  import cfg_engage_pkg::*;
;
  logic        aclk, aresetn, reconfig_req_n, program_done, tck, tms, tdi;
  logic [1:0]  scheme_select, s_axi_bresp, s_axi_rresp;
  logic        io_chain_reload, user_io_hiz, serial_push_idle, parallel_push_idle;
  logic        serial_push_resume, parallel_push_resume, reconfig_start;
  logic        config_status_n_o, config_status_n_oe, s_axi_awvalid, s_axi_awready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [9:0]  m_instr;
  int          n_errors, tests_run, c_rel, c_st, c_sr, c_pr, m_sidle, m_pidle, m_seen;

  jtag_config_engage_control uut (
    .aclk, .aresetn, .tck, .tms, .tdi, .scheme_select, .reconfig_req_n, .program_done,
    .io_chain_reload, .user_io_hiz, .serial_push_idle, .parallel_push_idle,
    .serial_push_resume, .parallel_push_resume, .reconfig_start, .config_status_n_o,
    .config_status_n_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  tap_host host (.tck, .tms, .tdi);

  always #2 aclk = ~aclk;
  // pulse counters; pulses are one cycle so counting beats sampling a moment
  always @(posedge aclk) begin
    c_rel <= c_rel + io_chain_reload;
    c_st  <= c_st + reconfig_start;
    c_sr  <= c_sr + serial_push_resume;
    c_pr  <= c_pr + parallel_push_resume;
  end

  // ==========================================================
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    close_out();
  end

  // ==========================================================
  // axi4-lite master
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int t;
    t = 0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 200);
    s_axi_bready <= 1'b0;
    chk("bvalid", {31'h0, s_axi_bvalid}, 32'h1);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int t;
    t = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 200);
    s_axi_rready <= 1'b0;
    chk("rvalid", {31'h0, s_axi_rvalid}, 32'h1);
    chk("rdata", s_axi_rdata, e);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // ==========================================================
  // one stimulus step: 0 instruction, 1 tap reset, 2 done pulse, 3 pin low
  task automatic op(input int k, input logic [9:0] code, input int len);
    int r0, s0, sr0, pr0, er, es, esr, epr;
    r0 = c_rel; s0 = c_st; sr0 = c_sr; pr0 = c_pr;
    er = 0; es = 0; esr = 0; epr = 0;
    if (k == 0) m_instr = code;
    if (k == 1) m_instr = INSTR_BYPASS;
    if (k == 0 && code == INSTR_IO_CHAIN) er = 1;
    if (k == 0 && code == INSTR_IDLE_CTRL) begin
      if (scheme_select == SCHEME_SERIAL_PUSH) m_sidle = 1;
      if (scheme_select == SCHEME_PARALLEL_PUSH) m_pidle = 1;
    end
    if (k == 2 || (k == 0 && code == INSTR_RESUME_CTRL)) begin
      esr = m_sidle; epr = m_pidle; m_sidle = 0; m_pidle = 0;
    end
    if (k == 1 && scheme_select == SCHEME_SERIAL_PUSH) begin
      esr = m_sidle; m_sidle = 0;
    end
    if (k == 0 && (code == INSTR_PULSE_RECFG || code == INSTR_RESUME_CTRL)) es = 1;
    if (k == 3 && len >= MIN_REQ_LOW_CYC && m_seen == 0) es = 1;
    if (k == 0 && code == INSTR_RESUME_CTRL) m_seen = 1;
    case (k)
      0: host.shift_ir(code);
      1: host.reset_tap();
      2: begin
        program_done <= 1'b1;
        @(posedge aclk);
        program_done <= 1'b0;
      end
      default: begin
        reconfig_req_n <= 1'b0;
        repeat (len) @(posedge aclk);
        reconfig_req_n <= 1'b1;
      end
    endcase
    repeat (30) @(posedge aclk);
    chk("reload", c_rel - r0, er);
    chk("start", c_st - s0, es);
    chk("serial_resume", c_sr - sr0, esr);
    chk("parallel_resume", c_pr - pr0, epr);
    axi_rd(OFS_STATUS, {25'h0, m_seen[0], m_instr == INSTR_IO_CHAIN, m_pidle[0],
                        m_sidle[0], scheme_select, 1'b1}, AXI_OKAY);
    axi_rd(OFS_INSTR, {22'h0, m_instr}, AXI_OKAY);
  endtask
  task automatic set_scheme(input logic [1:0] s);
    scheme_select <= s;
    repeat (10) @(posedge aclk);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    aclk = 1'b0; aresetn = 1'b0; reconfig_req_n = 1'b1; program_done = 1'b0;
    scheme_select = SCHEME_SERIAL_PULL; s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00;
    s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b0; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    n_errors = 0; tests_run = 0; c_rel = 0; c_st = 0; c_sr = 0; c_pr = 0;
    m_sidle = 0; m_pidle = 0; m_seen = 0; m_instr = INSTR_BYPASS;
    void'($urandom(47990));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(OFS_CONTROL, 32'h0, AXI_OKAY);
    axi_rd(OFS_INSTR, {22'h0, INSTR_BYPASS}, AXI_OKAY);
    axi_rd(8'h0c, 32'h0, AXI_DECERR);
    axi_wr(OFS_STATUS, 32'h1, AXI_DECERR);
    d = $urandom & 32'h3;
    axi_wr(OFS_CONTROL, d, AXI_OKAY);
    axi_rd(OFS_CONTROL, d, AXI_OKAY);
    axi_wr(OFS_CONTROL, 32'h3, AXI_OKAY);
    $display("end of register test");
    // pin high, status at its pull-up and no restart yet: io chain is safe only here
    op(1, 10'h0, 0);
    op(0, INSTR_IO_CHAIN, 0);
    chk("status_oe", {31'h0, config_status_n_oe}, 32'h0);
    chk("status_o", {31'h0, config_status_n_o}, 32'h0);
    op(0, INSTR_BYPASS, 0);
    op(0, INSTR_PULSE_RECFG, 0);
    op(3, 10'h0, MIN_REQ_LOW_CYC - 1);
    op(3, 10'h0, MIN_REQ_LOW_CYC + $urandom % 40);
    $display("end of io chain and request pin test");
    for (int s = 0; s < 4; s++) begin
      set_scheme(s[1:0]);
      op(0, INSTR_IDLE_CTRL, 0);
      op(1, 10'h0, 0);
      op(3, 10'h0, 200);
      op(0, INSTR_PROGRAM, 0);
      op(0, INSTR_CHECK, 0);
      op(0, INSTR_WAKEUP, 0);
      op(2, 10'h0, 0);
      op(1, 10'h0, 0);
      $display("end of scheme %0d test", s);
    end
    // resume is a last resort, and it turns the pin off for the rest of the run
    set_scheme(SCHEME_PARALLEL_PUSH);
    op(0, INSTR_IDLE_CTRL, 0);
    op(0, INSTR_RESUME_CTRL, 0);
    set_scheme(SCHEME_SERIAL_PULL);
    op(0, INSTR_RESUME_CTRL, 0);
    op(3, 10'h0, 200);
    $display("end of resume test");
    close_out();
  end
endmodule
